// file: rtl/vcc_pkg.sv
// Shared constants and types for the vertical sync, coast and clamp timing block
package vcc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned LINE_W = 12;
  localparam int unsigned DET_W  = 4;
  localparam int unsigned RUN_W  = 9;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_VERTICAL_SYNC_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_VERTICAL_SYNC_WIDTH   = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_COAST_LEAD_LINES      = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_COAST_TRAIL_LINES     = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_COAST_CLAMP_SELECT    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_START_DELAY     = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_LENGTH          = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_POLARITY_CTRL   = 8'h1b;

  // vertical_sync_control fields
  localparam int unsigned VS_SRC_OVR  = 7;
  localparam int unsigned VS_SRC_SEP  = 6;
  localparam int unsigned VS_POL_OVR  = 5;
  localparam int unsigned VS_POL_IN   = 4;
  localparam int unsigned VS_POL_OUT  = 3;
  localparam int unsigned VS_FILT_EN  = 2;
  localparam int unsigned VS_DUR_EN   = 1;
  localparam logic [DATA_W-1:0] VS_CTRL_MASK = 8'hfe;

  // coast_clamp_select fields
  localparam int unsigned CO_SRC_PIN  = 7;
  localparam int unsigned CO_POL_OVR  = 6;
  localparam int unsigned CO_POL_IN   = 5;
  localparam int unsigned CL_SRC_EXT  = 4;
  localparam int unsigned CL_MID_R    = 3;
  localparam int unsigned CL_MID_B    = 1;
  localparam logic [DATA_W-1:0] CC_SEL_MASK = 8'hfe;

  // clamp_polarity_offset_control fields
  localparam int unsigned CL_POL_OVR  = 7;
  localparam int unsigned CL_POL_IN   = 6;
  localparam logic [DATA_W-1:0] CL_POL_MASK = 8'hc0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_VS_CTRL   = 8'h18;
  localparam logic [DATA_W-1:0] RST_VS_WIDTH  = 8'h0a;
  localparam logic [DATA_W-1:0] RST_CO_LEAD   = 8'h00;
  localparam logic [DATA_W-1:0] RST_CO_TRAIL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CC_SEL    = 8'h20;
  localparam logic [DATA_W-1:0] RST_CL_DELAY  = 8'h08;
  localparam logic [DATA_W-1:0] RST_CL_LEN    = 8'h14;
  localparam logic [DATA_W-1:0] RST_CL_POL    = 8'h40;

  // Polarity detector slots
  localparam int unsigned DET_VS = 0;
  localparam int unsigned DET_CO = 1;
  localparam int unsigned DET_CL = 2;
  localparam int unsigned DET_N  = 3;

  typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} vcc_clamp_st_t;

  typedef struct packed {
    logic [DATA_W-1:0] vs_ctrl;
    logic [DATA_W-1:0] vs_width;
    logic [DATA_W-1:0] co_lead;
    logic [DATA_W-1:0] co_trail;
    logic [DATA_W-1:0] cc_sel;
    logic [DATA_W-1:0] cl_delay;
    logic [DATA_W-1:0] cl_len;
    logic [DATA_W-1:0] cl_pol;
  } vcc_regs_t;

  typedef struct packed {
    vcc_regs_t                    regs;
    logic [DATA_W-1:0]            rdata;
    logic [1:0]                   hs_s;
    logic [1:0]                   vs_s;
    logic [1:0]                   sep_s;
    logic [1:0]                   co_s;
    logic [1:0]                   cl_s;
    logic                         hs_prev;
    logic                         vs_act;
    logic [DET_N-1:0][DET_W-1:0]  det;
    logic [LINE_W-1:0]            line_cnt;
    logic [LINE_W-1:0]            frame_lines;
    logic [DATA_W-1:0]            trail_cnt;
    logic [DATA_W-1:0]            width_cnt;
    vcc_clamp_st_t                cl_st;
    logic [DATA_W-1:0]            cl_cnt;
    logic                         vs_out;
    logic                         coast;
    logic                         clamp;
    logic [2:0]                   clamp_mid;
  } vcc_state_t;

endpackage

// file: rtl/vcc_timing.sv
// Vertical sync conditioning, coast window and clamp window generation
//
// Behaviour
// - Vsync input polarity from override bit when override set; bit resets to 1.
// - Vsync output active low when polarity bit 0, high when 1; default 1.
// - Filter enabled aligns vsync changes to hsync leading edges; else bypass.
// - Duration enable 0 keeps vsync width; 1 uses width register.
// - Eight-bit vsync width, default 10, used only with duration enable.
// - Internal coast starts programmed hsync periods before vsync; default zero.
// - Internal coast extends programmed hsync periods after vsync; default zero.
// - Coast from vsync when source bit 0, from coast pin when 1.
// - Coast polarity detected unless override; then polarity bit, default 1.
// - Clamp source 0 makes internal clamp from hsync; 1 uses clamp pin.
// - Red, green and blue clamp together while selected clamp is active.
// - Per-channel target bit: 0 clamps to ground, 1 to midscale.
// - Internal clamp begins placement pixel periods after hsync trailing edge.
// - Internal clamp lasts programmed duration, default 20; zero unsupported.
// - External clamp ignores placement and duration values.
// - Clamp polarity detected unless override; then polarity bit, default 1.
// - Vsync polarity from bit when override set, else auto detected.
// - Vsync source select with override set: 0 picks input pin, 1 picks sync separator; override 0 picks pin.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module vcc_timing
  import vcc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [DATA_W-1:0] o_reg_rdata,
  // Sync and timing pins
  input  wire logic              i_hsync,
  input  wire logic              i_vsync,
  input  wire logic              i_sep_vsync,
  input  wire logic              i_coast_pin,
  input  wire logic              i_clamp_pin,
  // Conditioned outputs
  output logic                   o_vsync,
  output logic                   o_coast,
  output logic                   o_clamp,
  output logic      [2:0]        o_clamp_mid
);

  vcc_state_t s_q;
  vcc_state_t s_d;

  logic              hs;
  logic              hs_rise;
  logic              hs_fall;
  logic              vs_raw;
  logic              vs_pol;
  logic              vs_norm;
  logic              vs_rise;
  logic              vs_fall;
  logic              vs_pulse;
  logic              lead_win;
  logic              coast_int;
  logic              coast_ext;
  logic              clamp_ext;
  logic              ext_clamp_mode;
  logic [LINE_W:0]   lead_sum;
  logic [DET_N-1:0]  det_in;

  function automatic logic [DATA_W-1:0] reg_read(input vcc_regs_t r,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      ADDR_VERTICAL_SYNC_CONTROL: v = r.vs_ctrl;
      ADDR_VERTICAL_SYNC_WIDTH:   v = r.vs_width;
      ADDR_COAST_LEAD_LINES:      v = r.co_lead;
      ADDR_COAST_TRAIL_LINES:     v = r.co_trail;
      ADDR_COAST_CLAMP_SELECT:    v = r.cc_sel;
      ADDR_CLAMP_START_DELAY:     v = r.cl_delay;
      ADDR_CLAMP_LENGTH:          v = r.cl_len;
      ADDR_CLAMP_POLARITY_CTRL:   v = r.cl_pol;
      default:                    v = '0;
    endcase
    return v;
  endfunction

  // Majority of levels seen at hsync edges is the idle level of a sync pulse
  function automatic logic [DET_W-1:0] det_step(input logic [DET_W-1:0] c,
                                               input logic lvl);
    logic [DET_W-1:0] v;
    v = c;
    if (lvl && (c != '1))
    begin
      v = c + 1'b1;
    end
    else if (!lvl && (c != '0))
    begin
      v = c - 1'b1;
    end
    return v;
  endfunction

  always_comb
  begin
    s_d = s_q;
    // Pin synchronisers, stage 0 feeds only stage 1
    s_d.hs_s  = {s_q.hs_s[0], i_hsync};
    s_d.vs_s  = {s_q.vs_s[0], i_vsync};
    s_d.sep_s = {s_q.sep_s[0], i_sep_vsync};
    s_d.co_s  = {s_q.co_s[0], i_coast_pin};
    s_d.cl_s  = {s_q.cl_s[0], i_clamp_pin};
    hs         = s_q.hs_s[1];
    hs_rise    = hs & ~s_q.hs_prev;
    hs_fall    = ~hs & s_q.hs_prev;
    s_d.hs_prev = hs;

    // Register writes; reserved bits stay zero
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        ADDR_VERTICAL_SYNC_CONTROL: s_d.regs.vs_ctrl  = i_reg_wdata & VS_CTRL_MASK;
        ADDR_VERTICAL_SYNC_WIDTH:   s_d.regs.vs_width = i_reg_wdata;
        ADDR_COAST_LEAD_LINES:      s_d.regs.co_lead  = i_reg_wdata;
        ADDR_COAST_TRAIL_LINES:     s_d.regs.co_trail = i_reg_wdata;
        ADDR_COAST_CLAMP_SELECT:    s_d.regs.cc_sel   = i_reg_wdata & CC_SEL_MASK;
        ADDR_CLAMP_START_DELAY:     s_d.regs.cl_delay = i_reg_wdata;
        ADDR_CLAMP_LENGTH:          s_d.regs.cl_len   = i_reg_wdata;
        ADDR_CLAMP_POLARITY_CTRL:   s_d.regs.cl_pol   = i_reg_wdata & CL_POL_MASK;
        default:                    s_d.regs = s_q.regs;
      endcase
    end
    s_d.rdata = i_reg_rd ? reg_read(s_q.regs, i_reg_addr) : '0;

    // Source selection; without override the pin is taken
    vs_raw = (s_q.regs.vs_ctrl[VS_SRC_OVR] && s_q.regs.vs_ctrl[VS_SRC_SEP]) ?
             s_q.sep_s[1] : s_q.vs_s[1];

    // Auto polarity detectors, sampled once per line
    det_in = '0;
    det_in[DET_VS] = vs_raw;
    det_in[DET_CO] = s_q.co_s[1];
    det_in[DET_CL] = s_q.cl_s[1];
    for (int i = 0; i < DET_N; i++)
    begin
      if (hs_rise)
      begin
        s_d.det[i] = det_step(s_q.det[i], det_in[i]);
      end
    end

    vs_pol  = s_q.regs.vs_ctrl[VS_POL_OVR] ? s_q.regs.vs_ctrl[VS_POL_IN] :
              ~s_q.det[DET_VS][DET_W-1];
    vs_norm = vs_raw ~^ vs_pol;

    // Filter holds vsync changes until the next hsync leading edge
    if (s_q.regs.vs_ctrl[VS_FILT_EN])
    begin
      if (hs_rise)
      begin
        s_d.vs_act = vs_norm;
      end
    end
    else
    begin
      s_d.vs_act = vs_norm;
    end
    vs_rise = s_d.vs_act & ~s_q.vs_act;
    vs_fall = ~s_d.vs_act & s_q.vs_act;

    // Width block counts hsync periods from the vsync leading edge
    if (vs_rise)
    begin
      s_d.width_cnt = s_q.regs.vs_width;
    end
    else if (hs_rise && (s_q.width_cnt != '0))
    begin
      s_d.width_cnt = s_q.width_cnt - 1'b1;
    end
    vs_pulse   = s_q.regs.vs_ctrl[VS_DUR_EN] ? (s_d.width_cnt != '0) : s_d.vs_act;
    s_d.vs_out = vs_pulse ~^ s_q.regs.vs_ctrl[VS_POL_OUT];

    // Line counter predicts the next vsync from the last frame length
    if (vs_rise)
    begin
      s_d.frame_lines = s_q.line_cnt;
      s_d.line_cnt    = '0;
    end
    else if (hs_rise && (s_q.line_cnt != '1))
    begin
      s_d.line_cnt = s_q.line_cnt + 1'b1;
    end
    if (vs_fall)
    begin
      s_d.trail_cnt = s_q.regs.co_trail;
    end
    else if (hs_rise && (s_q.trail_cnt != '0))
    begin
      s_d.trail_cnt = s_q.trail_cnt - 1'b1;
    end
    lead_sum  = {1'b0, s_q.line_cnt} + {{(LINE_W + 1 - DATA_W){1'b0}}, s_q.regs.co_lead};
    // Lead window needs one measured frame; first frame coasts from vsync only
    // A frame spans frame_lines + 1 hsync periods, so the compare is strict
    lead_win  = (s_q.regs.co_lead != '0) && (s_q.frame_lines != '0) &&
                (lead_sum > {1'b0, s_q.frame_lines});
    coast_int = s_q.vs_act | lead_win | (s_q.trail_cnt != '0);
    coast_ext = s_q.co_s[1] ~^ (s_q.regs.cc_sel[CO_POL_OVR] ? s_q.regs.cc_sel[CO_POL_IN] :
                                ~s_q.det[DET_CO][DET_W-1]);
    s_d.coast = s_q.regs.cc_sel[CO_SRC_PIN] ? coast_ext : coast_int;

    // Clamp window
    ext_clamp_mode = s_q.regs.cc_sel[CL_SRC_EXT];
    clamp_ext = s_q.cl_s[1] ~^ (s_q.regs.cl_pol[CL_POL_OVR] ? s_q.regs.cl_pol[CL_POL_IN] :
                                ~s_q.det[DET_CL][DET_W-1]);
    if (ext_clamp_mode)
    begin
      s_d.cl_st  = CL_IDLE;
      s_d.cl_cnt = '0;
    end
    else if (hs_fall)
    begin
      s_d.cl_st  = CL_WAIT;
      s_d.cl_cnt = s_q.regs.cl_delay;
    end
    else
    begin
      case (s_q.cl_st)
        CL_IDLE: s_d.cl_st = CL_IDLE;
        CL_WAIT:
        begin
          if (s_q.cl_cnt <= 8'h01)
          begin
            s_d.cl_st  = CL_ON;
            s_d.cl_cnt = s_q.regs.cl_len;
          end
          else
          begin
            s_d.cl_cnt = s_q.cl_cnt - 1'b1;
          end
        end
        CL_ON:
        begin
          if (s_q.cl_cnt <= 8'h01)
          begin
            s_d.cl_st = CL_IDLE;
          end
          else
          begin
            s_d.cl_cnt = s_q.cl_cnt - 1'b1;
          end
        end
        default: s_d.cl_st = CL_IDLE;
      endcase
    end
    s_d.clamp     = ext_clamp_mode ? clamp_ext : (s_d.cl_st == CL_ON);
    s_d.clamp_mid = s_q.regs.cc_sel[CL_MID_R:CL_MID_B];
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q               <= '0;
      s_q.regs.vs_ctrl  <= RST_VS_CTRL;
      s_q.regs.vs_width <= RST_VS_WIDTH;
      s_q.regs.co_lead  <= RST_CO_LEAD;
      s_q.regs.co_trail <= RST_CO_TRAIL;
      s_q.regs.cc_sel   <= RST_CC_SEL;
      s_q.regs.cl_delay <= RST_CL_DELAY;
      s_q.regs.cl_len   <= RST_CL_LEN;
      s_q.regs.cl_pol   <= RST_CL_POL;
      s_q.cl_st         <= CL_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata = s_q.rdata;
  assign o_vsync     = s_q.vs_out;
  assign o_coast     = s_q.coast;
  assign o_clamp     = s_q.clamp;
  assign o_clamp_mid = s_q.clamp_mid;

  // Helper counters read only by the checks below
  // Placement and length are captured as the hardware takes them, so that
  // software rewriting them mid-line does not trip the checks
  logic [RUN_W-1:0]  since_fall_q;
  logic [RUN_W-1:0]  clamp_run_q;
  logic [DATA_W-1:0] delay_seen_q;
  logic [DATA_W-1:0] clamp_len_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      since_fall_q <= '0;
      clamp_run_q  <= '0;
      delay_seen_q <= '0;
      clamp_len_q  <= '0;
    end
    else
    begin
      since_fall_q <= hs_fall ? 9'h001 :
                      ((since_fall_q != '1) ? since_fall_q + 1'b1 : since_fall_q);
      clamp_run_q  <= (o_clamp && !ext_clamp_mode) ? clamp_run_q + 1'b1 : '0;
      delay_seen_q <= hs_fall ? s_q.regs.cl_delay : delay_seen_q;
      clamp_len_q  <= o_clamp ? clamp_len_q : s_q.regs.cl_len;
    end
  end

  AST_VS_INPOL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.regs.vs_ctrl[VS_POL_OVR] && !s_q.regs.vs_ctrl[VS_FILT_EN] &&
    !s_q.regs.vs_ctrl[VS_SRC_SEP] |=>
    s_q.vs_act == ($past(s_q.vs_s[1]) ~^ $past(s_q.regs.vs_ctrl[VS_POL_IN])))
    else $error("vsync input polarity not from override bit");

  AST_VS_OUTPOL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !s_q.regs.vs_ctrl[VS_DUR_EN] && $past(!s_q.regs.vs_ctrl[VS_DUR_EN]) &&
    $stable(s_q.regs.vs_ctrl[VS_POL_OUT]) |->
    o_vsync == (s_q.vs_act ~^ s_q.regs.vs_ctrl[VS_POL_OUT]))
    else $error("vsync output level does not follow output polarity");

  AST_VS_FILTER: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(s_q.regs.vs_ctrl[VS_FILT_EN]) && $changed(s_q.vs_act) |-> $past(hs_rise))
    else $error("filtered vsync changed away from an hsync edge");

  AST_VS_BYPASS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(!s_q.regs.vs_ctrl[VS_FILT_EN]) |-> s_q.vs_act == $past(vs_norm))
    else $error("vsync filter not bypassed");

  AST_VS_WIDTH: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    vs_rise && s_q.regs.vs_ctrl[VS_DUR_EN] |=> s_q.width_cnt == $past(s_q.regs.vs_width))
    else $error("vsync width not loaded from width register");

  AST_COAST_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(s_q.regs.cc_sel[CO_SRC_PIN]) |-> o_coast == $past(coast_ext))
    else $error("coast not taken from coast pin");

  AST_COAST_VS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(!s_q.regs.cc_sel[CO_SRC_PIN]) && $past(s_q.vs_act) |-> o_coast)
    else $error("internal coast dropped during vsync");

  AST_CLAMP_EXT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(ext_clamp_mode) |-> o_clamp == $past(clamp_ext) && s_q.cl_st == CL_IDLE)
    else $error("external clamp not passed through");

  AST_CLAMP_START: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(o_clamp) && !ext_clamp_mode && $past(!ext_clamp_mode) &&
    (delay_seen_q != '0) |->
    since_fall_q == {1'b0, delay_seen_q} + 9'h001)
    else $error("internal clamp start misplaced after hsync trailing edge");

  AST_CLAMP_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (clamp_len_q != '0) && !ext_clamp_mode |->
    clamp_run_q <= {1'b0, clamp_len_q})
    else $error("internal clamp longer than programmed length");

  AST_CLAMP_MID: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    i_reg_wr && (i_reg_addr == ADDR_COAST_CLAMP_SELECT) |->
    ##2 o_clamp_mid == $past(i_reg_wdata[CL_MID_R:CL_MID_B], 2))
    else $error("clamp targets do not follow select register");

endmodule

`default_nettype wire

// file: dv/vcc_src_model.sv
// Video source model: line and frame timing for hsync, vsync pins, coast and clamp pins
`timescale 1ns/1ns
`default_nettype none

module vcc_src_model #(
  parameter int LINE  = 40,
  parameter int HS_W  = 4,
  parameter int FRAME = 20
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Controls from the bench
  input  wire logic i_vs_pol,
  input  wire logic i_coast_lvl,
  input  wire logic i_clamp_lvl,
  // Source pins
  output logic      o_hsync,
  output logic      o_vsync,
  output logic      o_sep_vsync,
  output logic      o_coast_pin,
  output logic      o_clamp_pin
);
  int px;
  int ln;
  int pos;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      px <= 0;
      ln <= 0;
    end
    else if (px == LINE - 1)
    begin
      px <= 0;
      ln <= (ln == FRAME - 1) ? 0 : ln + 1;
    end
    else
      px <= px + 1;
  end

  // Vsync edges fall mid-line so that alignment to hsync can be seen
  assign pos         = ln * LINE + px;
  assign o_hsync     = px < HS_W;
  assign o_vsync     = (pos >= 10 * LINE + 20 && pos < 13 * LINE + 20) ^ ~i_vs_pol;
  assign o_sep_vsync = pos >= 4 * LINE + 20 && pos < 6 * LINE + 20;
  assign o_coast_pin = i_coast_lvl;
  assign o_clamp_pin = i_clamp_lvl;
endmodule

`default_nettype wire

// file: dv/tb_vcc_timing.sv
// Self-checking bench for the vertical sync, coast and clamp timing block
`timescale 1ns/1ns
`default_nettype none

module tb_vcc_timing;
  import vcc_pkg::*;

  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} vcc_row_t;

  logic              sys_clk = 1'b0;
  logic              arst_n  = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              vs_pol = 1'b1;
  logic              coast_lvl = 1'b0;
  logic              clamp_lvl = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              hsync, vsync, sep_vsync, coast_pin, clamp_pin;
  logic              o_vsync, o_coast, o_clamp;
  logic [2:0]        o_clamp_mid;
  logic [7:0]        rdv;
  int                n_fail = 0;
  int                tests_run = 0;
  int                n, n1;
  vcc_row_t          rows [10] = '{'{8'h15, 8'h33, 8'h33}, '{8'h14, 8'hff, 8'hfe},
    '{8'h18, 8'hff, 8'hfe}, '{8'h1b, 8'hff, 8'hc0}, '{8'h16, 8'h07, 8'h07},
    '{8'h17, 8'h09, 8'h09}, '{8'h19, 8'hff, 8'hff}, '{8'h1a, 8'h01, 8'h01},
    '{8'h13, 8'h55, 8'h00}, '{8'h1c, 8'haa, 8'h00}};
  logic [7:0]        rv [8] = '{8'h18, 8'h0a, 8'h00, 8'h00, 8'h20, 8'h08, 8'h14, 8'h40};

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  vcc_src_model vcc_src_model_inst (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_vs_pol(vs_pol),
    .i_coast_lvl(coast_lvl), .i_clamp_lvl(clamp_lvl), .o_hsync(hsync), .o_vsync(vsync),
    .o_sep_vsync(sep_vsync), .o_coast_pin(coast_pin), .o_clamp_pin(clamp_pin));

  vcc_timing vcc_timing_inst (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_hsync(hsync), .i_vsync(vsync), .i_sep_vsync(sep_vsync), .i_coast_pin(coast_pin),
    .i_clamp_pin(clamp_pin), .o_vsync(o_vsync), .o_coast(o_coast), .o_clamp(o_clamp),
    .o_clamp_mid(o_clamp_mid));

  task automatic end_sim();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // frame_cnt counts whole frames, so its result does not depend on phase
  task automatic cnt(input int s, input int len, output int c);
    c = 0;
    repeat (len)
    begin
      @(negedge sys_clk);
      c += (s == 0) ? int'(o_vsync) : (s == 1) ? int'(o_coast) : int'(o_clamp);
    end
  endtask

  // Cycles from a source edge (vsync rise or hsync fall) to the output going active
  task automatic lag(input int s, output int c);
    c = 0;
    do @(negedge sys_clk); while ((s ? hsync : vsync) !== 1'(s));
    do @(negedge sys_clk); while ((s ? hsync : vsync) !== 1'(!s));
    while ((s ? o_clamp : o_vsync) !== 1'b1 && c < 1000)
    begin
      @(negedge sys_clk);
      c++;
    end
  endtask

  task automatic frame_cnt(input int s, input logic [31:0] e);
    repeat (1600) @(posedge sys_clk);
    cnt(s, 800, n);
    chk(n, e);
    @(posedge sys_clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    end_sim();
  end

  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rdv);
      chk(rdv, rows[i].e);
    end
    @(negedge sys_clk);
    chk(reg_rdata, 8'h00);
    $display("register rows done");
    do_reset();
    for (int i = 0; i < 8; i++)
    begin
      rd(8'h14 + 8'(i), rdv);
      chk(rdv, rv[i]);
    end
    $display("reset values done");
    frame_cnt(0, 120);
    vs_pol <= 1'b0;
    frame_cnt(0, 120);
    wr(8'h14, 8'hb8);
    frame_cnt(0, 680);
    wr(8'h14, 8'ha8);
    frame_cnt(0, 120);
    wr(8'h14, 8'ha0);
    frame_cnt(0, 680);
    vs_pol <= 1'b1;
    wr(8'h14, 8'hf8);
    frame_cnt(0, 80);
    wr(8'h14, 8'hb8);
    lag(0, n);
    chk(n <= 4, 1);
    wr(8'h14, 8'hbc);
    lag(0, n);
    chk(n >= 18 && n <= 26, 1);
    frame_cnt(0, 120);
    wr(8'h15, 8'h05);
    wr(8'h14, 8'hbe);
    frame_cnt(0, 200);
    wr(8'h15, 8'h01);
    frame_cnt(0, 40);
    $display("vsync tests done");
    // Filter kept on while coast is extended, with the sync filter alike
    wr(8'h14, 8'hbc);
    frame_cnt(1, 120);
    wr(8'h17, 8'h02);
    frame_cnt(1, 200);
    wr(8'h16, 8'h02);
    frame_cnt(1, 280);
    wr(8'h18, 8'he0);
    coast_lvl <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(o_coast, 1'b1);
    wr(8'h18, 8'hc0);
    repeat (5) @(negedge sys_clk);
    chk(o_coast, 1'b0);
    @(posedge sys_clk);
    coast_lvl <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(o_coast, 1'b1);
    // Auto polarity: a pin held high long enough is taken as idle high
    wr(8'h18, 8'ha0);
    coast_lvl <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(o_coast, 1'b1);
    repeat (600) @(negedge sys_clk);
    chk(o_coast, 1'b0);
    $display("coast tests done");
    // Placement and length kept in 1..255, clamp inside the back porch
    wr(8'h18, 8'h0a);
    wr(8'h19, 8'h03);
    wr(8'h1a, 8'h05);
    @(negedge sys_clk);
    chk(o_clamp_mid, 3'b101);
    frame_cnt(2, 100);
    lag(1, n1);
    wr(8'h19, 8'h08);
    repeat (80) @(posedge sys_clk);
    lag(1, n);
    chk(n - n1, 5);
    wr(8'h18, 8'h10);
    wr(8'h1b, 8'hc0);
    repeat (5) @(negedge sys_clk);
    chk(o_clamp, 1'b0);
    fork
      begin
        @(posedge sys_clk);
        clamp_lvl <= 1'b1;
        repeat (7) @(posedge sys_clk);
        clamp_lvl <= 1'b0;
      end
      cnt(2, 30, n);
    join
    chk(n, 7);
    wr(8'h1b, 8'h80);
    repeat (5) @(negedge sys_clk);
    chk(o_clamp, 1'b1);
    wr(8'h1b, 8'h00);
    clamp_lvl <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(o_clamp, 1'b1);
    repeat (600) @(negedge sys_clk);
    chk(o_clamp, 1'b0);
    $display("clamp tests done");
    end_sim();
  end
endmodule

`default_nettype wire
